// ==== logic/sdc_top.sv ====
// Purpose: Divider configuration for a clock synthesizer, reached over APB
// Assumes: All pins synchronous to pclk; APB answers after one wait cycle
// Notes: Analog loop and lock detection sit outside this block
`timescale 1ns/100ps
`include "sdc_regs.svh"

// Behaviour
// - Pre-divider bit: 0 gives two, 1 four
// - Feedback divider is ten-bit unsigned binary
// - Post-divider code decodes to two through sixty-four
// - Output A ratio is the post-divider
// - Output B optionally halved relative to A
// - Output frequency follows pre, feedback, post ratios
// - Parallel select low: pins drive dividers
// - Pin changes apply at once in parallel
// - Master reset release captures pins always
// - Open pins load the default setting
// - Parallel mode ignores all register writes
// - Parallel mode still serves register reads
// - Parallel mode mirrors pins into registers
// - Parallel mode executes no command
// - After select rises, only registers and master reset program
// - Low and high register field layout
// - Select fall reloads pins, rise keeps
// - Serial dividers change only on load, increment or decrement commands or on master reset
module sdc_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic master_reset_n,
    input wire logic parallel_select_n,
    input wire logic cfg_pins_open,
    input wire logic [9:0] cfg_feedback_div,
    input wire logic [2:0] cfg_post_divider_code,
    input wire logic cfg_second_output_halver,
    input wire logic cfg_pre_div,
    input wire logic lock_status,
    output logic [9:0] feedback_div,
    output logic [2:0] post_divider_code,
    output logic second_output_halver,
    output logic pre_div_sel,
    output logic [2:0] pre_div_ratio,
    output logic [6:0] clock_output_a_ratio,
    output logic [7:0] clock_output_b_ratio,
    output logic fb_in_range
);
    import sdc_pkg::*;

    // ****************************************************************
    // State and decode signals
    // ****************************************************************
    sdc_state_t s_r;
    sdc_state_t s_nxt;
    sdc_cfg_t pin_cfg;
    sdc_cfg_t def_cfg;
    sdc_cfg_t reg_cfg;
    logic serial_mode;
    logic addr_ok;
    logic hit_low;
    logic hit_high;
    logic hit_cmd;
    logic hit_id;
    logic [3:0] cmd_code;

    // ****************************************************************
    // Post-divider decode
    // ****************************************************************
    function automatic logic [6:0] post_ratio(input logic [2:0] code);
        logic [6:0] r;
        r = 7'h08;
        case (code)
            3'b000: r = 7'h02;
            3'b100: r = 7'h04;
            3'b010: r = 7'h08;
            3'b110: r = 7'h10;
            3'b001: r = 7'h20;
            3'b101: r = 7'h40;
            // Unlisted codes fall back to the default ratio
            default: r = 7'h08;
        endcase
        return r;
    endfunction

    // ****************************************************************
    // Configuration sources
    // ****************************************************************
    always_comb begin
        def_cfg.fb = `SDC_DEF_FB;
        def_cfg.post = `SDC_DEF_POST;
        def_cfg.halver = `SDC_DEF_HALVER;
        def_cfg.pre = `SDC_DEF_PRE;
        if (cfg_pins_open) begin
            pin_cfg = def_cfg;
        end else begin
            pin_cfg.fb = cfg_feedback_div;
            pin_cfg.post = cfg_post_divider_code;
            pin_cfg.halver = cfg_second_output_halver;
            pin_cfg.pre = cfg_pre_div;
        end
        // Lock bit is not part of the latched setting
        reg_cfg.fb = {s_r.high_reg[`SDC_HI_FB_MSB - 1:`SDC_HI_FB_LSB - 1], s_r.low_reg};
        reg_cfg.post = s_r.high_reg[`SDC_HI_POST_MSB - 1:`SDC_HI_POST_LSB - 1];
        reg_cfg.halver = s_r.high_reg[`SDC_HI_HALVER - 1];
        reg_cfg.pre = s_r.high_reg[`SDC_HI_PRE - 1];
    end

    // ****************************************************************
    // Address decode
    // ****************************************************************
    always_comb begin
        serial_mode = parallel_select_n;
        addr_ok = (paddr[1:0] == 2'b00);
        hit_low = addr_ok && (paddr[11:2] == `SDC_IDX_LOW);
        hit_high = addr_ok && (paddr[11:2] == `SDC_IDX_HIGH);
        hit_cmd = addr_ok && (paddr[11:2] == `SDC_IDX_CMD);
        hit_id = addr_ok && (paddr[11:2] == `SDC_IDX_ID);
        // Upper command nibble is don't-care
        cmd_code = pwdata[3:0];
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt = s_r;

        // APB: first access cycle decides, second commits with pready
        case (s_r.ap)
            AP_IDLE: begin
                if (psel && penable) begin
                    s_nxt.ap = AP_ANSWER;
                    s_nxt.pready = 1'b1;
                    s_nxt.prdata = 32'h0000_0000;
                    s_nxt.wr_ok = 1'b0;
                    s_nxt.pslverr = 1'b0;
                    if (pwrite) begin
                        if (hit_low || hit_high || hit_cmd) begin
                            s_nxt.wr_ok = serial_mode;
                            s_nxt.pslverr = !serial_mode;
                        end else begin
                            // Identification is read only
                            s_nxt.pslverr = 1'b1;
                        end
                    end else if (hit_low) begin
                        s_nxt.prdata = {24'h00_0000, s_r.low_reg};
                    end else if (hit_high) begin
                        s_nxt.prdata = {24'h00_0000, s_r.high_reg, lock_status};
                    end else if (hit_id) begin
                        s_nxt.prdata = {24'h00_0000, `SDC_ID_VALUE};
                    end else begin
                        // Command register and holes cannot be read
                        s_nxt.pslverr = 1'b1;
                    end
                end
            end
            AP_ANSWER: begin
                s_nxt.ap = AP_IDLE;
                s_nxt.pready = 1'b0;
                s_nxt.pslverr = 1'b0;
                s_nxt.wr_ok = 1'b0;
                s_nxt.prdata = 32'h0000_0000;
                // Mode rechecked so a late select fall still blocks
                if (s_r.wr_ok && pwrite && serial_mode) begin
                    if (hit_low) begin
                        s_nxt.low_reg = pwdata[7:0];
                    end else if (hit_high) begin
                        s_nxt.high_reg = pwdata[7:1];
                    end else if (hit_cmd) begin
                        case (cmd_code)
                            `SDC_CMD_INC: s_nxt.act.fb = s_r.act.fb + 10'd1;
                            `SDC_CMD_DEC: s_nxt.act.fb = s_r.act.fb - 10'd1;
                            `SDC_CMD_LOAD: s_nxt.act = reg_cfg;
                            `SDC_CMD_GET: begin
                                s_nxt.low_reg = s_r.act.fb[7:0];
                                s_nxt.high_reg = {s_r.act.fb[9:8], s_r.act.post,
                                    s_r.act.halver, s_r.act.pre};
                            end
                            // Unknown commands do nothing
                            default: s_nxt.act = s_r.act;
                        endcase
                    end
                end
            end
            default: begin
                s_nxt.ap = AP_IDLE;
                s_nxt.pready = 1'b0;
            end
        endcase

        // Startup and mode selection override register traffic
        case (s_r.su)
            SU_PEND: begin
                if (master_reset_n) begin
                    s_nxt.su = SU_RUN;
                    s_nxt.act = pin_cfg;
                end else begin
                    s_nxt.su = SU_HOLD;
                    s_nxt.act = def_cfg;
                end
            end
            SU_HOLD: begin
                if (master_reset_n) begin
                    s_nxt.su = SU_RUN;
                    s_nxt.act = pin_cfg;
                end else begin
                    s_nxt.act = def_cfg;
                end
            end
            SU_RUN: begin
                if (!master_reset_n) begin
                    s_nxt.su = SU_HOLD;
                    s_nxt.act = def_cfg;
                end else if (!parallel_select_n) begin
                    // Select fall reloads on the same edge as any pin change
                    s_nxt.act = pin_cfg;
                end
                // Serial mode leaves the setting as it stands
            end
            default: begin
                s_nxt.su = SU_HOLD;
                s_nxt.act = def_cfg;
            end
        endcase

        // Registers follow the setting whenever pins are in charge
        if ((s_r.su != SU_RUN) || !master_reset_n || !parallel_select_n) begin
            s_nxt.low_reg = s_nxt.act.fb[7:0];
            s_nxt.high_reg = {s_nxt.act.fb[9:8], s_nxt.act.post,
                s_nxt.act.halver, s_nxt.act.pre};
        end

        // Ratios follow the setting taking effect
        s_nxt.pre_ratio = s_nxt.act.pre ? 3'd4 : 3'd2;
        s_nxt.a_ratio = post_ratio(s_nxt.act.post);
        s_nxt.b_ratio = s_nxt.act.halver ? {s_nxt.a_ratio, 1'b0}
            : {1'b0, s_nxt.a_ratio};
        // Range flag only reports; the setting is never refused
        s_nxt.fb_in_range = (s_nxt.act.fb >= `SDC_FB_MIN)
            && (s_nxt.act.fb <= `SDC_FB_MAX);
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s_r.ap <= AP_IDLE;
            s_r.su <= SU_PEND;
            s_r.pready <= 1'b0;
            s_r.pslverr <= 1'b0;
            s_r.prdata <= 32'h0000_0000;
            s_r.wr_ok <= 1'b0;
            s_r.low_reg <= 8'(`SDC_DEF_FB);
            s_r.high_reg <= {2'b01, `SDC_DEF_POST, `SDC_DEF_HALVER, `SDC_DEF_PRE};
            s_r.act.fb <= `SDC_DEF_FB;
            s_r.act.post <= `SDC_DEF_POST;
            s_r.act.halver <= `SDC_DEF_HALVER;
            s_r.act.pre <= `SDC_DEF_PRE;
            s_r.pre_ratio <= 3'd4;
            s_r.a_ratio <= 7'h08;
            s_r.b_ratio <= 8'h08;
            s_r.fb_in_range <= 1'b1;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata = s_r.prdata;
    assign pready = s_r.pready;
    assign pslverr = s_r.pslverr;
    assign feedback_div = s_r.act.fb;
    assign post_divider_code = s_r.act.post;
    assign second_output_halver = s_r.act.halver;
    assign pre_div_sel = s_r.act.pre;
    assign pre_div_ratio = s_r.pre_ratio;
    assign clock_output_a_ratio = s_r.a_ratio;
    assign clock_output_b_ratio = s_r.b_ratio;
    assign fb_in_range = s_r.fb_in_range;

endmodule // sdc_top

// ==== logic/sdc_regs.svh ====
// Purpose: Offsets, fields, reset values and commands of the divider config block
// Assumes: Register indexes are word indexes; byte address is four times the index
// Notes: Definitions only
`ifndef SDC_REGS_SVH
`define SDC_REGS_SVH

// ****************************************************************
// Register indexes
// ****************************************************************
`define SDC_IDX_LOW 10'h000
`define SDC_IDX_HIGH 10'h001
`define SDC_IDX_CMD 10'h0f0
`define SDC_IDX_ID 10'h008

// ****************************************************************
// High register field positions
// ****************************************************************
`define SDC_HI_FB_MSB 7
`define SDC_HI_FB_LSB 6
`define SDC_HI_POST_MSB 5
`define SDC_HI_POST_LSB 3
`define SDC_HI_HALVER 2
`define SDC_HI_PRE 1
`define SDC_HI_LOCK 0

// ****************************************************************
// Defaults and commands
// ****************************************************************
`define SDC_DEF_FB 10'h1f4
`define SDC_DEF_POST 3'b010
`define SDC_DEF_HALVER 1'b0
`define SDC_DEF_PRE 1'b1
`define SDC_CMD_INC 4'h1
`define SDC_CMD_DEC 4'h2
`define SDC_CMD_LOAD 4'h4
`define SDC_CMD_GET 4'h8
`define SDC_FB_MIN 10'd136
`define SDC_FB_MAX 10'd725
// Identification value, arbitrary
`define SDC_ID_VALUE 8'h5a

`endif

// ==== logic/sdc_pkg.sv ====
// Purpose: Types of the divider config block
// Assumes: Constants live in sdc_regs.svh
// Notes: One packed struct carries all state
package sdc_pkg;

    typedef enum logic {AP_IDLE, AP_ANSWER} sdc_apb_st_t;

    typedef enum logic [1:0] {SU_PEND, SU_HOLD, SU_RUN} sdc_start_st_t;

    typedef struct packed {
        logic [9:0] fb;
        logic [2:0] post;
        logic halver;
        logic pre;
    } sdc_cfg_t;

    typedef struct packed {
        sdc_apb_st_t ap;
        sdc_start_st_t su;
        logic pready;
        logic pslverr;
        logic [31:0] prdata;
        logic wr_ok;
        logic [7:0] low_reg;
        logic [6:0] high_reg;
        sdc_cfg_t act;
        logic [2:0] pre_ratio;
        logic [6:0] a_ratio;
        logic [7:0] b_ratio;
        logic fb_in_range;
    } sdc_state_t;

endpackage

// ==== tb/sdc_top_sva.sv ====
// Purpose: Port-level checks of the divider config block
// Assumes: APB answers after one wait cycle
// Notes: Bound into sdc_top below
`timescale 1ns/100ps
`include "sdc_regs.svh"
module sdc_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic master_reset_n,
    input wire logic parallel_select_n,
    input wire logic cfg_pins_open,
    input wire logic [9:0] cfg_feedback_div,
    input wire logic [9:0] feedback_div,
    input wire logic [2:0] post_divider_code,
    input wire logic second_output_halver,
    input wire logic pre_div_sel,
    input wire logic [2:0] pre_div_ratio,
    input wire logic [6:0] clock_output_a_ratio,
    input wire logic [7:0] clock_output_b_ratio,
    input wire logic fb_in_range
);
    logic [2:0] rv;
    logic [1:0] age_r;
    // ************************************************
    // Checks
    // ************************************************
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    assign rv = {post_divider_code[0], post_divider_code[1], post_divider_code[2]};
    // Startup capture is a one-off, so hold checks wait it out
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            age_r <= 2'h0;
        end else if (age_r != 2'h3) begin
            age_r <= age_r + 2'h1;
        end
    end
    a_pre_ratio: assert property (pre_div_ratio == (pre_div_sel ? 3'h4 : 3'h2))
        else $error("pre ratio wrong");
    a_post_ratio: assert property (clock_output_a_ratio == ((rv > 3'h5) ? 7'h08 : 7'h02 << rv))
        else $error("output a ratio wrong");
    a_b_ratio: assert property (clock_output_b_ratio ==
        (second_output_halver ? {clock_output_a_ratio, 1'b0} : {1'b0, clock_output_a_ratio}))
        else $error("output b ratio wrong");
    a_fb_range: assert property (fb_in_range == (feedback_div >= 10'd136 && feedback_div <= 10'd725))
        else $error("range flag wrong");
    a_pins_follow: assert property ((!parallel_select_n && master_reset_n && !cfg_pins_open)
        |=> feedback_div == $past(cfg_feedback_div)) else $error("pins not followed");
    a_open_default: assert property ((master_reset_n && cfg_pins_open && !parallel_select_n)
        |=> feedback_div == `SDC_DEF_FB && post_divider_code == `SDC_DEF_POST)
        else $error("open pins default wrong");
    a_par_write_err: assert property ((psel && penable && pwrite && pready && !parallel_select_n)
        |-> pslverr) else $error("parallel write accepted");
    a_serial_hold: assert property ((age_r == 2'h3 && parallel_select_n && master_reset_n
        && $past(master_reset_n) && !pready) |=> $stable(feedback_div) && $stable(post_divider_code))
        else $error("serial dividers moved");
    a_answer_wait: assert property ((psel && penable && !pready) |=> pready)
        else $error("no answer after one wait");
endmodule // sdc_chk
bind sdc_top sdc_chk sdc_chk_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pready(pready), .pslverr(pslverr), .master_reset_n(master_reset_n),
    .parallel_select_n(parallel_select_n), .cfg_pins_open(cfg_pins_open),
    .cfg_feedback_div(cfg_feedback_div), .feedback_div(feedback_div),
    .post_divider_code(post_divider_code), .second_output_halver(second_output_halver),
    .pre_div_sel(pre_div_sel), .pre_div_ratio(pre_div_ratio),
    .clock_output_a_ratio(clock_output_a_ratio), .clock_output_b_ratio(clock_output_b_ratio),
    .fb_in_range(fb_in_range));

// ==== tb/sdc_pins.sv ====
// Purpose: Board side model: strap pins, mode pins and lock level
// Assumes: Pins change just after a rising pclk edge
// Notes: Tasks are called from the bench
`timescale 1ns/100ps
module sdc_pins (
    input wire logic pclk,
    output logic master_reset_n,
    output logic parallel_select_n,
    output logic cfg_pins_open,
    output logic [9:0] cfg_feedback_div,
    output logic [2:0] cfg_post_divider_code,
    output logic cfg_second_output_halver,
    output logic cfg_pre_div,
    output logic lock_status
);
    // ************************************************
    // Straps
    // ************************************************
    initial begin
        {master_reset_n, parallel_select_n, cfg_pins_open, lock_status} = 4'b1101;
        {cfg_feedback_div, cfg_post_divider_code} = {10'h2aa, 3'b100};
        {cfg_second_output_halver, cfg_pre_div} = 2'b10;
    end
    // Out-of-range values only when the bench asks for them
    task automatic cfg(input logic [9:0] fb, input logic [2:0] na, input logic [1:0] hp);
        @(posedge pclk);
        cfg_feedback_div <= fb;
        cfg_post_divider_code <= na;
        {cfg_second_output_halver, cfg_pre_div} <= hp;
    endtask
    task automatic mode(input logic [3:0] m);
        @(posedge pclk);
        {master_reset_n, parallel_select_n, cfg_pins_open, lock_status} <= m;
    endtask
endmodule // sdc_pins

// ==== tb/synth_divider_config_test.sv ====
// Purpose: Self-checking bench of the divider config block
// Assumes: One APB wait cycle; pins follow one edge later
// Notes: Board straps come from sdc_pins
`timescale 1ns/100ps
`include "sdc_regs.svh"
module synth_divider_config_test;
    logic pclk, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata;
    logic master_reset_n, parallel_select_n, cfg_pins_open, cfg_second_output_halver;
    logic cfg_pre_div, lock_status, second_output_halver, pre_div_sel, fb_in_range;
    logic [9:0] cfg_feedback_div, feedback_div;
    logic [2:0] cfg_post_divider_code, post_divider_code, pre_div_ratio;
    logic [6:0] clock_output_a_ratio;
    logic [7:0] clock_output_b_ratio;
    int checks = 0, mismatches = 0;
    localparam logic [11:0] ad_lo = {`SDC_IDX_LOW, 2'b00};
    localparam logic [11:0] ad_hi = {`SDC_IDX_HIGH, 2'b00};
    localparam logic [11:0] ad_id = {`SDC_IDX_ID, 2'b00};
    localparam logic [11:0] ad_cm = {`SDC_IDX_CMD, 2'b00};
    logic [9:0] fbv [6] = '{10'd135, 10'd136, 10'd725, 10'd726, 10'd500, 10'd512};
    logic [2:0] nav [6] = '{3'b000, 3'b100, 3'b010, 3'b110, 3'b001, 3'b101};
    logic [6:0] arv [6] = '{7'd2, 7'd4, 7'd8, 7'd16, 7'd32, 7'd64};
    logic inv [6] = '{1'b0, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};
    logic [3:0] cmv [4] = '{4'h1, 4'h2, 4'h2, 4'h3};
    logic [9:0] cfv [4] = '{10'h0f1, 10'h0f0, 10'h0ef, 10'h0ef};
    sdc_top sdc_top_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .master_reset_n(master_reset_n), .parallel_select_n(parallel_select_n),
        .cfg_pins_open(cfg_pins_open), .cfg_feedback_div(cfg_feedback_div),
        .cfg_post_divider_code(cfg_post_divider_code), .cfg_pre_div(cfg_pre_div),
        .cfg_second_output_halver(cfg_second_output_halver), .lock_status(lock_status),
        .feedback_div(feedback_div), .post_divider_code(post_divider_code),
        .second_output_halver(second_output_halver), .pre_div_sel(pre_div_sel),
        .pre_div_ratio(pre_div_ratio), .clock_output_a_ratio(clock_output_a_ratio),
        .clock_output_b_ratio(clock_output_b_ratio), .fb_in_range(fb_in_range));
    sdc_pins sdc_pins_i (.pclk(pclk), .master_reset_n(master_reset_n),
        .parallel_select_n(parallel_select_n), .cfg_pins_open(cfg_pins_open),
        .cfg_feedback_div(cfg_feedback_div), .cfg_post_divider_code(cfg_post_divider_code),
        .cfg_second_output_halver(cfg_second_output_halver), .cfg_pre_div(cfg_pre_div),
        .lock_status(lock_status));
    // ************************************************
    // Tasks
    // ************************************************
    initial begin
        pclk = 1'b0;
        forever #20 pclk = ~pclk;
    end
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic st(input logic [9:0] fb, input logic [2:0] na, input logic [1:0] hp);
        chk(32'({feedback_div, post_divider_code, second_output_halver, pre_div_sel}),
            32'({fb, na, hp}));
    endtask
    // Request held until pready is seen at an edge
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        input logic ee, input logic [31:0] exp);
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        @(posedge pclk);
        while (pready !== 1'b1) @(posedge pclk);
        chk(32'(pslverr), 32'(ee));
        if (!w && !ee) chk(prdata, exp);
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic end_sim;
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        repeat (4000) @(posedge pclk);
        mismatches++;
        end_sim;
    end
    initial begin
        tk(20);
        presetn <= 1'b1;
        tk(2);
        st(10'h2aa, 3'b100, 2'b10);
        chk(32'({pre_div_ratio, clock_output_a_ratio, clock_output_b_ratio}), 32'(18'h10408));
        xfer(1'b0, ad_lo, 32'h0, 1'b0, 32'haa);
        xfer(1'b0, ad_hi, 32'h0, 1'b0, 32'ha5);
        xfer(1'b0, ad_id, 32'h0, 1'b0, 32'(`SDC_ID_VALUE));
        xfer(1'b0, ad_cm, 32'h0, 1'b1, 32'h0);
        xfer(1'b0, 12'h010, 32'h0, 1'b1, 32'h0);
        xfer(1'b0, 12'h001, 32'h0, 1'b1, 32'h0);
        xfer(1'b1, ad_lo, 32'hf0, 1'b0, 32'h0);
        xfer(1'b1, ad_hi, 32'hffff_ff03, 1'b0, 32'h0);
        st(10'h2aa, 3'b100, 2'b10);
        sdc_pins_i.mode(4'b1100);
        xfer(1'b0, ad_hi, 32'h0, 1'b0, 32'h02);
        xfer(1'b1, ad_cm, 32'hf4, 1'b0, 32'h0);
        tk(1);
        st(10'h0f0, 3'b000, 2'b01);
        chk(32'({pre_div_ratio, clock_output_a_ratio, clock_output_b_ratio}), 32'(18'h20202));
        for (int i = 0; i < 4; i++) begin
            xfer(1'b1, ad_cm, 32'(cmv[i]), 1'b0, 32'h0);
            tk(1);
            chk(32'(feedback_div), 32'(cfv[i]));
        end
        xfer(1'b0, ad_lo, 32'h0, 1'b0, 32'hf0);
        xfer(1'b1, ad_cm, 32'h8, 1'b0, 32'h0);
        xfer(1'b0, ad_lo, 32'h0, 1'b0, 32'hef);
        sdc_pins_i.mode(4'b1000);
        tk(2);
        st(10'h2aa, 3'b100, 2'b10);
        for (int i = 0; i < 6; i++) begin
            sdc_pins_i.cfg(fbv[i], nav[i], 2'b10);
            tk(2);
            st(fbv[i], nav[i], 2'b10);
            chk(32'(fb_in_range), 32'(inv[i]));
            chk(32'(clock_output_a_ratio), 32'(arv[i]));
            chk(32'(clock_output_b_ratio), 32'({arv[i], 1'b0}));
        end
        sdc_pins_i.cfg(10'h1c2, 3'b110, 2'b10);
        xfer(1'b1, ad_lo, 32'h11, 1'b1, 32'h0);
        xfer(1'b1, ad_cm, 32'h1, 1'b1, 32'h0);
        st(10'h1c2, 3'b110, 2'b10);
        xfer(1'b0, ad_lo, 32'h0, 1'b0, 32'hc2);
        xfer(1'b0, ad_hi, 32'h0, 1'b0, 32'h74);
        sdc_pins_i.mode(4'b1010);
        tk(2);
        st(10'h1f4, 3'b010, 2'b01);
        sdc_pins_i.mode(4'b1000);
        sdc_pins_i.mode(4'b1100);
        sdc_pins_i.cfg(10'h200, 3'b000, 2'b01);
        tk(2);
        st(10'h1c2, 3'b110, 2'b10);
        sdc_pins_i.mode(4'b0100);
        tk(2);
        st(10'h1f4, 3'b010, 2'b01);
        sdc_pins_i.mode(4'b1100);
        tk(2);
        st(10'h200, 3'b000, 2'b01);
        end_sim;
    end
endmodule // synth_divider_config_test
